// file: hdl/fef_pkg.sv
// fef_pkg: constants for the feedback event flag bank
// assumes: 8-bit register port, 40-bit position words
package fef_pkg;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned POS_W  = 40;
   localparam int unsigned QM_W   = 4;

   // register offsets
   localparam logic [7:0] OFF_QUALITY     = 8'h03;
   localparam logic [7:0] OFF_EVENT_HIGH  = 8'h04;
   localparam logic [7:0] OFF_EVENT_MASK  = 8'h10;
   localparam logic [7:0] OFF_DIGEST_MASK = 8'h11;
   localparam logic [7:0] OFF_DEV_LIMIT   = 8'h12;
   localparam logic [7:0] OFF_CONTROL     = 8'h13;

   // event_flags_high bit positions
   localparam int unsigned BIT_INT   = 7;
   localparam int unsigned BIT_SUM   = 6;
   localparam int unsigned BIT_SCE   = 5;
   localparam int unsigned BIT_NONE  = 4;
   localparam int unsigned BIT_EST   = 3;
   localparam int unsigned BIT_SENSOR_POSITION_ERR  = 2;
   localparam int unsigned BIT_DTE   = 1;
   localparam int unsigned BIT_RLINK = 0;
   localparam int unsigned BIT_CTRL_RELINK = 0;

   // which bits software may clear, which follow their level
   localparam logic [7:0] CLEARABLE_MASK = 8'h6F;
   localparam logic [7:0] LEVEL_MASK     = 8'h42;

   // reset values
   localparam logic [7:0] EVENT_RESET       = 8'h00;
   localparam logic [7:0] EVENT_MASK_RESET  = 8'h00;
   localparam logic [7:0] DIGEST_MASK_RESET = 8'h00;
   localparam logic [7:0] DEV_LIMIT_RESET   = 8'hFF;
   localparam logic [39:0] POS_RESET        = 40'h00_0000_0000;

   // link quality counter
   localparam logic [3:0] QM_INIT     = 4'h8;
   localparam logic [3:0] QM_MAX      = 4'hF;
   localparam logic [3:0] QM_LOW      = 4'hE;
   localparam logic [3:0] QM_ZERO     = 4'h0;
   localparam logic [3:0] QM_SAFE_ERR = 4'h6;
   localparam logic [3:0] QM_GOOD     = 4'h1;

   // position shown while the sensor reports an error
   localparam logic [39:0] POS_ERR_PATTERN = 40'hFD_FDFD_FDFD;
endpackage : fef_pkg

// file: hdl/fef_flag_cell.sv
// fef_flag_cell: one sticky event flag, edge or level kind
// assumes: condition input synchronous to clk_in
`timescale 1ns/10ps
`default_nettype none
module fef_flag_cell #(
   parameter bit LEVEL = 1'b0
) (
   input  wire logic clk_in,
   input  wire logic resetn_in,
   input  wire logic cond_in,
   input  wire logic clr_in,
   output var  logic flag_out
);
   logic cond_q;
   logic set_now;

   // edge kind needs the condition to drop before it can fire again
   assign set_now = LEVEL ? cond_in : (cond_in & ~cond_q); // R4 R5

   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
         cond_q <= 1'b0;
      else
         cond_q <= cond_in;
   end

   // set beats clear; hardware never drops the flag by itself
   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
         flag_out <= 1'b0; // R17
      else
         flag_out <= set_now | (flag_out & ~clr_in); // R1 R2 R20
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!resetn_in);

   a_set_wins_clr: assert property (set_now |=> flag_out) // R20
      else $error("flag lost when set and clear coincide");
   a_flag_sticky: assert property (flag_out && !clr_in |=> flag_out) // R2
      else $error("flag dropped without a clear");
   a_edge_refire: assert property (
      !LEVEL && cond_q && cond_in && flag_out ##1 clr_in && cond_in
      |=> !flag_out) // R4
      else $error("edge flag set again while condition held");
endmodule : fef_flag_cell
`default_nettype wire

// file: hdl/fef_event_flags.sv
// fef_event_flags: high-byte event bank of a motor-feedback link master
// assumes: one clock, synchronous condition inputs, plain register port
//
// Strobed register access is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
// How it works
// (R1) each flag is set when its warning or error condition is seen
// (R2) the block never clears a set flag; only software does
// (R3) software clears the flags it finds and handles each condition
// (R4) edge flags set at condition start, again only after it ends
// (R5) level flags stay set while their condition lasts
// (R6) online status shows every condition live, unlatched
// (R7) bit 7 at 04h is read-only and mirrors the interrupt output
// (R8) bit 6 is set while an enabled remote slave event is pending
// (R9) software reads the slave summary when bit 6 is set
// (R10) bit 5 is set on a safe-channel consistency error
// (R11) each safe-channel error lowers the link quality value, except in a relink cycle
// (R12) safe position holds its last valid value across safe-channel errors
// (R13) bit 4 always reads zero
// (R14) bit 3 set on fast error; fast position then from estimator
// (R15) bit 2 set on sensor error; error pattern replaces positions
// (R16) bit 1 follows deviation above the configured limit
// (R17) all bits reset to zero; bits 7 and 4 read-only, rest clearable
// (R18) bit 0 is set on any forced relink, whatever its source
// (R19) quality reaching zero forces a relink
// (R20) writing ones clears flags; a same-cycle set still wins
module fef_event_flags (
   input  wire logic        clk_in,
   input  wire logic        resetn_in,
   input  wire logic [7:0]  addr_in,
   input  wire logic [7:0]  wdata_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   output var  logic [7:0]  rdata_out,
   input  wire logic [7:0]  slave_summary_in,
   input  wire logic        safe_err_in,
   input  wire logic        safe_valid_in,
   input  wire logic [39:0] safe_pos_in,
   input  wire logic        fast_err_in,
   input  wire logic [39:0] fast_pos_in,
   input  wire logic [39:0] est_pos_in,
   input  wire logic        sensor_err_in,
   input  wire logic [7:0]  deviation_in,
   input  wire logic        relink_req_in,
   output var  logic        irq_out,
   output var  logic [7:0]  online_status_out,
   output var  logic [39:0] safe_pos_out,
   output var  logic [39:0] fast_pos_out,
   output var  logic [3:0]  quality_out,
   output var  logic        link_quality_low_warn_out,
   output var  logic        relink_out
);
   logic [7:0]  flags;
   logic [7:0]  cond;
   logic [7:0]  clr;
   logic [7:0]  event_mask;
   logic [7:0]  remote_digest_mask;
   logic [7:0]  dev_limit;
   logic        sw_relink;
   logic        relink_now;
   logic [3:0]  next_quality;
   logic [7:0]  next_rdata;

   function automatic logic hit(input logic [7:0] a,
                                input logic [7:0] off);
      hit = (a == off);
   endfunction : hit

   // register writes

   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
         event_mask <= fef_pkg::EVENT_MASK_RESET;
      else if (wr_in && hit(addr_in, fef_pkg::OFF_EVENT_MASK))
         event_mask <= wdata_in;
   end

   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
         remote_digest_mask <= fef_pkg::DIGEST_MASK_RESET;
      else if (wr_in && hit(addr_in, fef_pkg::OFF_DIGEST_MASK))
         remote_digest_mask <= wdata_in;
   end

   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
         dev_limit <= fef_pkg::DEV_LIMIT_RESET;
      else if (wr_in && hit(addr_in, fef_pkg::OFF_DEV_LIMIT))
         dev_limit <= wdata_in;
   end

   // relink request bit is self-clearing, reads back as zero
   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
         sw_relink <= 1'b0;
      else
         sw_relink <= wr_in && hit(addr_in, fef_pkg::OFF_CONTROL)
                      && wdata_in[fef_pkg::BIT_CTRL_RELINK];
   end

   // write-one-to-clear on the event register
   assign clr = (wr_in && hit(addr_in, fef_pkg::OFF_EVENT_HIGH))
                ? (wdata_in & fef_pkg::CLEARABLE_MASK)
                : 8'h00; // R20

   // conditions

   assign relink_now = sw_relink | relink_req_in
                       | (quality_out == fef_pkg::QM_ZERO); // R18 R19

   always_comb
   begin
      cond = 8'h00;
      cond[fef_pkg::BIT_SUM]   = |(slave_summary_in
                                   & remote_digest_mask); // R8
      cond[fef_pkg::BIT_SCE]   = safe_err_in; // R10
      cond[fef_pkg::BIT_EST]   = fast_err_in; // R14
      cond[fef_pkg::BIT_SENSOR_POSITION_ERR]  = sensor_err_in; // R15
      cond[fef_pkg::BIT_DTE]   = deviation_in > dev_limit; // R16
      cond[fef_pkg::BIT_RLINK] = relink_now; // R18
   end

   // one cell per implemented flag; bits 7 and 4 hold no state
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++)
      begin : g_flag
         if (fef_pkg::CLEARABLE_MASK[gi])
         begin : g_cell
            fef_flag_cell #(
               .LEVEL (fef_pkg::LEVEL_MASK[gi])
            ) u_cell (
               .clk_in    (clk_in),
               .resetn_in (resetn_in),
               .cond_in   (cond[gi]),
               .clr_in    (clr[gi]),
               .flag_out  (flags[gi])
            ); // R1 R2 R4 R5 R17
         end
         else
         begin : g_zero
            assign flags[gi] = 1'b0; // R13
         end
      end
   endgenerate

   // interrupt and online status

   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
         irq_out <= 1'b0;
      else
         irq_out <= |(flags & event_mask);
   end

   // live copy, one register stage, no latching
   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
         online_status_out <= fef_pkg::EVENT_RESET;
      else
         online_status_out <= cond; // R6
   end

   // link quality

   always_comb
   begin
      next_quality = quality_out;
      if (relink_now)
         next_quality = fef_pkg::QM_INIT;
      else if (safe_err_in)
      begin
         if (quality_out > fef_pkg::QM_SAFE_ERR)
            next_quality = quality_out - fef_pkg::QM_SAFE_ERR; // R11
         else
            next_quality = fef_pkg::QM_ZERO; // R11
      end
      else if (safe_valid_in && quality_out != fef_pkg::QM_MAX)
         next_quality = quality_out + fef_pkg::QM_GOOD;
   end

   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
         quality_out <= fef_pkg::QM_INIT;
      else
         quality_out <= next_quality;
   end

   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
         link_quality_low_warn_out <= 1'b0;
      else
         link_quality_low_warn_out <= next_quality < fef_pkg::QM_LOW;
   end

   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
         relink_out <= 1'b0;
      else
         relink_out <= relink_now; // R19
   end

   // positions

   // a bad safe frame keeps the old value; fast path is untouched
   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
         safe_pos_out <= fef_pkg::POS_RESET;
      else if (sensor_err_in)
         safe_pos_out <= fef_pkg::POS_ERR_PATTERN; // R15
      else if (safe_valid_in && !safe_err_in)
         safe_pos_out <= safe_pos_in; // R12
   end

   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
         fast_pos_out <= fef_pkg::POS_RESET;
      else if (sensor_err_in)
         fast_pos_out <= fef_pkg::POS_ERR_PATTERN; // R15
      else if (flags[fef_pkg::BIT_EST])
         fast_pos_out <= est_pos_in; // R14
      else
         fast_pos_out <= fast_pos_in;
   end

   // register reads; data only in the cycle after the strobe

   always_comb
   begin
      next_rdata = 8'h00;
      if (hit(addr_in, fef_pkg::OFF_EVENT_HIGH))
      begin
         next_rdata = flags;
         next_rdata[fef_pkg::BIT_INT] = irq_out; // R7
      end
      else if (hit(addr_in, fef_pkg::OFF_QUALITY))
         next_rdata = {4'h0, quality_out};
      else if (hit(addr_in, fef_pkg::OFF_EVENT_MASK))
         next_rdata = event_mask;
      else if (hit(addr_in, fef_pkg::OFF_DIGEST_MASK))
         next_rdata = remote_digest_mask;
      else if (hit(addr_in, fef_pkg::OFF_DEV_LIMIT))
         next_rdata = dev_limit;
   end

   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
         rdata_out <= 8'h00;
      else if (rd_in)
         rdata_out <= next_rdata;
      else
         rdata_out <= 8'h00;
   end

   // checks

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!resetn_in);

   sequence s_read_event;
      rd_in && addr_in == fef_pkg::OFF_EVENT_HIGH;
   endsequence

   sequence s_qm_empty;
      quality_out == fef_pkg::QM_ZERO;
   endsequence

   sequence s_event_clear;
      wr_in && addr_in == fef_pkg::OFF_EVENT_HIGH;
   endsequence

   a_int_mirror: assert property ( // R7
      s_read_event |=> rdata_out[fef_pkg::BIT_INT] == $past(irq_out))
      else $error("bit 7 does not mirror interrupt output");

   a_bit4_zero: assert property ( // R13
      s_read_event |=> !rdata_out[fef_pkg::BIT_NONE])
      else $error("bit 4 read as one");

   a_online_live: assert property ( // R6
      ##1 online_status_out == $past(cond))
      else $error("online status not live copy");

   a_sum_level: assert property ( // R8
      |(slave_summary_in & remote_digest_mask)
      |=> flags[fef_pkg::BIT_SUM])
      else $error("remote summary flag not held");

   a_qm_relink: assert property ( // R19
      s_qm_empty |=> flags[fef_pkg::BIT_RLINK] && relink_out
                     && quality_out == fef_pkg::QM_INIT)
      else $error("empty quality did not force relink");

   // bit 0 is edge kind, so only a fresh relink must set it
   a_relink_req: assert property ( // R18
      relink_req_in && !$past(relink_now)
      |=> flags[fef_pkg::BIT_RLINK] && relink_out)
      else $error("relink input did not set flag");

   a_qm_drop: assert property ( // R11
      safe_err_in && !relink_now
      && quality_out > fef_pkg::QM_SAFE_ERR
      |=> quality_out == $past(quality_out) - fef_pkg::QM_SAFE_ERR)
      else $error("safe error did not lower quality");

   a_safe_hold: assert property ( // R12
      safe_err_in && !sensor_err_in |=> $stable(safe_pos_out))
      else $error("safe position changed on error");

   a_sensor_pat: assert property ( // R15
      sensor_err_in |=> fast_pos_out == fef_pkg::POS_ERR_PATTERN
                       && safe_pos_out == fef_pkg::POS_ERR_PATTERN)
      else $error("sensor error pattern not shown");

   a_est_select: assert property ( // R14
      flags[fef_pkg::BIT_EST] && !sensor_err_in
      |=> fast_pos_out == $past(est_pos_in))
      else $error("fast position not from estimator");

   a_dte_level: assert property ( // R16
      deviation_in > dev_limit |=> flags[fef_pkg::BIT_DTE]
      ##0 online_status_out[fef_pkg::BIT_DTE])
      else $error("deviation flag not set over limit");

   a_sce_set: assert property ( // R10
      safe_err_in && !$past(safe_err_in) |=> flags[fef_pkg::BIT_SCE])
      else $error("safe channel flag not set");

   // a clear with no set beside it must take the flag down
   a_clear_takes: assert property ( // R20
      s_event_clear ##0 (wdata_in[fef_pkg::BIT_SCE] && !safe_err_in)
      |=> !flags[fef_pkg::BIT_SCE])
      else $error("written one did not clear safe flag");

   a_sw_relink: assert property ( // R18
      sw_relink && !$past(relink_now) |=> flags[fef_pkg::BIT_RLINK])
      else $error("software relink did not set flag");
endmodule : fef_event_flags
`default_nettype wire

// file: sim/tb.sv
// tb: self-checking bench for the feedback event flag bank
// assumes: fef_pkg and the design files are compiled before this file
`timescale 1ns/10ps
`default_nettype none
module tb;
   typedef struct packed {logic [1:0] sel; logic [7:0] flags;} fef_row_t;

   logic        clk_in = 1'b0;
   logic        resetn_in = 1'b0;
   logic [7:0]  addr, wdata, summary, dev, rdata, online;
   logic        wr, rd, s_err, s_val, f_err, v_err, rl_req;
   logic [39:0] s_pos, f_pos, e_pos, s_out, f_out;
   logic [3:0]  qual;
   logic        irq, low_warn, relink;
   int          fail_count = 0;
   int          check_count = 0;
   int          n;
   // one condition pulse per row, flag expected on the register
   fef_row_t    rows [4] = '{'{2'h0, 8'h20}, '{2'h1, 8'h08},
                             '{2'h2, 8'h04}, '{2'h3, 8'h01}};

   fef_event_flags u_dut (
      .clk_in                    (clk_in),
      .resetn_in                 (resetn_in),
      .addr_in                   (addr),
      .wdata_in                  (wdata),
      .wr_in                     (wr),
      .rd_in                     (rd),
      .rdata_out                 (rdata),
      .slave_summary_in          (summary),
      .safe_err_in               (s_err),
      .safe_valid_in             (s_val),
      .safe_pos_in               (s_pos),
      .fast_err_in               (f_err),
      .fast_pos_in               (f_pos),
      .est_pos_in                (e_pos),
      .sensor_err_in             (v_err),
      .deviation_in              (dev),
      .relink_req_in             (rl_req),
      .irq_out                   (irq),
      .online_status_out         (online),
      .safe_pos_out              (s_out),
      .fast_pos_out              (f_out),
      .quality_out               (qual),
      .link_quality_low_warn_out (low_warn),
      .relink_out                (relink)
   );

   always #12.5 clk_in = ~clk_in;

   task end_sim;
      if (fail_count == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : end_sim

   task chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e)
      begin
         fail_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk8

   task chk40(input string nm, input logic [39:0] e, input logic [39:0] g);
      check_count++;
      if (g !== e)
      begin
         fail_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk40

   task cycles(input int c);
      repeat (c) @(posedge clk_in);
      #1;
   endtask : cycles

   task wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk_in);
      wr    <= 1'b0;
   endtask : wr_reg

   // read data stand only in the cycle after the strobe
   task rd_chk(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_in);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk_in);
      rd   <= 1'b0;
      #1;
      chk8("rdata", e, rdata);
   endtask : rd_chk

   task set_cond(input logic [1:0] s, input logic v);
      @(posedge clk_in);
      case (s)
         2'h0: s_err <= v;
         2'h1: f_err <= v;
         2'h2: v_err <= v;
         default: rl_req <= v;
      endcase
   endtask : set_cond

   initial
   begin
      repeat (5000) @(posedge clk_in);
      fail_count++;
      end_sim();
   end

   initial
   begin
      {addr, wdata, summary, dev, wr, rd} = '0;
      {s_err, s_val, f_err, v_err, rl_req} = '0;
      s_pos = 40'h0;
      f_pos = 40'h11_2233_4455;
      e_pos = 40'h66_7788_99AA;
      repeat (16) @(posedge clk_in);
      resetn_in <= 1'b1;
      rd_chk(8'h04, 8'h00);
      rd_chk(8'h03, 8'h08);
      for (int i = 0; i < 4; i++)
      begin
         set_cond(rows[i].sel, 1'b1);
         set_cond(rows[i].sel, 1'b0);
         #1;
         chk8("online", rows[i].flags, online);
         cycles(1);
         chk8("online", 8'h00, online);
         rd_chk(8'h04, rows[i].flags);
         wr_reg(8'h04, 8'hFF);
         rd_chk(8'h04, 8'h00);
      end
      rd_chk(8'h03, 8'h08);
      // edge flag held high: a clear must stick until the next rise
      set_cond(2'h1, 1'b1);
      cycles(2);
      rd_chk(8'h04, 8'h08);
      wr_reg(8'h04, 8'h08);
      rd_chk(8'h04, 8'h00);
      set_cond(2'h1, 1'b0);
      set_cond(2'h1, 1'b1);
      set_cond(2'h1, 1'b0);
      rd_chk(8'h04, 8'h08);
      wr_reg(8'h04, 8'h08);
      // back-to-back safe errors empty the quality value
      set_cond(2'h0, 1'b1);
      cycles(1);
      chk8("quality", 8'h02, {4'h0, qual});
      chk8("low_warn", 8'h01, {7'h0, low_warn});
      set_cond(2'h0, 1'b0);
      n = 0;
      while (relink !== 1'b1 && n < 20)
      begin
         cycles(1);
         n++;
      end
      chk8("relink", 8'h01, {7'h0, relink});
      chk8("quality", 8'h08, {4'h0, qual});
      rd_chk(8'h04, 8'h21);
      // level flags survive a clear while their cause lasts
      wr_reg(8'h12, 8'h0A);
      wr_reg(8'h11, 8'h01);
      @(posedge clk_in);
      dev     <= 8'h0B;
      summary <= 8'h02;
      cycles(2);
      wr_reg(8'h04, 8'hFF);
      rd_chk(8'h04, 8'h02);
      @(posedge clk_in);
      summary <= 8'h01;
      cycles(2);
      chk8("online", 8'h42, online);
      wr_reg(8'h04, 8'hFF);
      rd_chk(8'h04, 8'h42);
      @(posedge clk_in);
      dev     <= 8'h0A;
      summary <= 8'h00;
      cycles(2);
      wr_reg(8'h04, 8'hFF);
      rd_chk(8'h04, 8'h00);
      // interrupt mirror and the bits software cannot touch
      wr_reg(8'h10, 8'h20);
      set_cond(2'h0, 1'b1);
      set_cond(2'h0, 1'b0);
      cycles(2);
      chk8("irq", 8'h01, {7'h0, irq});
      rd_chk(8'h04, 8'hA0);
      wr_reg(8'h04, 8'h90);
      rd_chk(8'h04, 8'hA0);
      wr_reg(8'h04, 8'h20);
      rd_chk(8'h04, 8'h00);
      rd_chk(8'h7F, 8'h00);
      // safe position keeps the last good value across an error
      @(posedge clk_in);
      s_pos <= 40'h12_3456_789A;
      s_val <= 1'b1;
      @(posedge clk_in);
      s_pos <= 40'h0F_0F0F_0F0F;
      s_err <= 1'b1;
      @(posedge clk_in);
      s_val <= 1'b0;
      s_err <= 1'b0;
      cycles(2);
      chk40("safe_pos", 40'h12_3456_789A, s_out);
      set_cond(2'h1, 1'b1);
      set_cond(2'h1, 1'b0);
      cycles(2);
      chk40("fast_pos", e_pos, f_out);
      wr_reg(8'h04, 8'h08);
      cycles(2);
      chk40("fast_pos", f_pos, f_out);
      set_cond(2'h2, 1'b1);
      cycles(2);
      chk40("safe_pos", 40'hFD_FDFD_FDFD, s_out);
      chk40("fast_pos", 40'hFD_FDFD_FDFD, f_out);
      set_cond(2'h2, 1'b0);
      cycles(2);
      chk40("fast_pos", f_pos, f_out);
      // software relink request shows on bit 0
      wr_reg(8'h04, 8'hFF);
      wr_reg(8'h13, 8'h01);
      cycles(2);
      rd_chk(8'h04, 8'h01);
      // six good frames lift quality out of the warning band
      @(posedge clk_in);
      s_val <= 1'b1;
      repeat (6) @(posedge clk_in);
      s_val <= 1'b0;
      #1;
      chk8("quality", 8'h0E, {4'h0, qual});
      chk8("low_warn", 8'h00, {7'h0, low_warn});
      end_sim();
   end
endmodule : tb
`default_nettype wire
